// file: dtd_decode.sv
`timescale 1ns/10ps
`default_nettype none

package dtd_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int          CLK_FREQ_MHZ    = 50;
  localparam int          CLK_PERIOD_NS   = 1000 / CLK_FREQ_MHZ;
  localparam logic [15:0] CLK_PERIOD_NS16 = 16'(CLK_PERIOD_NS);

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [3:0]  OFS_INSTR   = 4'h0;
  localparam logic [3:0]  OFS_CONFIG  = 4'h4;
  localparam logic [3:0]  OFS_RESULT  = 4'h8;
  localparam logic [3:0]  OFS_TIME    = 4'hC;
  localparam logic [31:0] INSTR_RST   = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RST  = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK = 32'h0000_07F1;

  // Configuration fields.
  localparam int CFG_PROT_BIT = 0;
  localparam int CFG_WAIT_LSB = 4;
  localparam int CFG_PFX_LSB  = 8;

  // Result fields.
  localparam int RES_TOTAL_LSB    = 0;
  localparam int RES_BASE_LSB     = 8;
  localparam int RES_MEM_BIT      = 13;
  localparam int RES_EA2_BIT      = 14;
  localparam int RES_FULL_BIT     = 15;
  localparam int RES_CLASS_LSB    = 16;
  localparam int RES_COMP_LSB     = 20;
  localparam int RES_VALID_BIT    = 24;
  localparam int RES_UNKNOWN_BIT  = 25;
  localparam int RES_BASEONLY_BIT = 26;

  // ****************************************************************
  // Instruction classes
  // ****************************************************************
  localparam logic [3:0] CLS_NONE      = 4'h0;
  localparam logic [3:0] CLS_TO_RM     = 4'h1;
  localparam logic [3:0] CLS_FROM_RM   = 4'h2;
  localparam logic [3:0] CLS_IMM_REG   = 4'h3;
  localparam logic [3:0] CLS_ACC_LOAD  = 4'h4;
  localparam logic [3:0] CLS_ACC_STORE = 4'h5;
  localparam logic [3:0] CLS_SEG_LOAD  = 4'h6;
  localparam logic [3:0] CLS_SEG_STORE = 4'h7;
  localparam logic [3:0] CLS_SIGN_EXT  = 4'h8;
  localparam logic [3:0] CLS_ZERO_EXT  = 4'h9;
  localparam logic [3:0] CLS_PUSH_SEG2 = 4'hA;
  localparam logic [3:0] CLS_PUSH_SEG3 = 4'hB;
  localparam logic [3:0] CLS_PUSH_IMM  = 4'hC;

  // ****************************************************************
  // Opcodes and clock counts
  // ****************************************************************
  localparam logic [7:0] OPC_ESCAPE    = 8'h0F;
  localparam logic [7:0] OPC_SEG_LOAD  = 8'h8E;
  localparam logic [7:0] OPC_SEG_STORE = 8'h8C;

  localparam logic [4:0] CLK_XFER        = 5'h02;
  localparam logic [4:0] CLK_LOAD_MEM    = 5'h04;
  localparam logic [4:0] CLK_SEG_REG_RM  = 5'h02;
  localparam logic [4:0] CLK_SEG_MEM_RM  = 5'h05;
  localparam logic [4:0] CLK_SEG_REG_PM  = 5'h12;
  localparam logic [4:0] CLK_SEG_MEM_PM  = 5'h13;
  localparam logic [4:0] CLK_EXT_REG     = 5'h03;
  localparam logic [4:0] CLK_EXT_MEM     = 5'h06;
  localparam logic [4:0] CLK_PUSH        = 5'h02;
  localparam logic [4:0] CLK_ACC_LOAD    = 5'h04;
  localparam logic [4:0] CLK_ACC_STORE   = 5'h02;
  localparam logic [4:0] CLK_IMM_REG     = 5'h02;
  localparam logic [7:0] CLK_EA_TWO_REG  = 8'h01;
  localparam logic [7:0] CLK_PER_WAIT    = 8'h01;

  // Picks the register or the memory figure of a two-figure count.
  function automatic logic [4:0] dtd_pick(input logic mem, input logic [4:0] r,
                                          input logic [4:0] m);
    return mem ? m : r;
  endfunction : dtd_pick

endpackage : dtd_pkg

module dtd_decode
  import dtd_pkg::*;
(
  // Instruction bytes and mode
  input  wire logic [31:0] instr,
  input  wire logic        prot_mode,
  // Decoded results
  output logic      [3:0]  op_class,
  output logic      [4:0]  base_clk,
  output logic             mem_op,
  output logic             ea_two_reg,
  output logic             full_size,
  output logic      [3:0]  comp_cnt,
  output logic             data_access
);

  wire logic [7:0] b0       = instr[7:0];
  wire logic [7:0] b1       = instr[15:8];
  wire logic       two_byte = (b0 == OPC_ESCAPE);
  wire logic [7:0] modrm    = two_byte ? instr[23:16] : b1;
  wire logic [7:0] sib      = two_byte ? instr[31:24] : instr[23:16];
  wire logic [1:0] md       = modrm[7:6];
  wire logic [2:0] rm       = modrm[2:0];

  // ****************************************************************
  // Opcode recognition
  // ****************************************************************
  wire logic hit_to_rm    = !two_byte && (b0[7:1] == 7'h44);                       // RL7
  wire logic hit_from_rm  = !two_byte && (b0[7:1] == 7'h45);                       // RL8
  wire logic hit_imm_reg  = (b0[7:4] == 4'hB);                                     // RL9
  wire logic hit_acc_ld   = (b0[7:1] == 7'h50);                                    // RL10
  wire logic hit_acc_st   = (b0[7:1] == 7'h51);                                    // RL11
  wire logic hit_seg_ld   = (b0 == OPC_SEG_LOAD) && (modrm[5:3] <= 3'h5)
                            && (modrm[5:3] != 3'h1);                                // RL12
  wire logic hit_seg_st   = (b0 == OPC_SEG_STORE) && (modrm[5:3] <= 3'h5);         // RL13
  wire logic hit_sign_ext = two_byte && (b1[7:1] == 7'h5F);                        // RL14
  wire logic hit_zero_ext = two_byte && (b1[7:1] == 7'h5B);                        // RL15
  wire logic hit_push_s2  = (b0[7:5] == 3'h0) && (b0[2:0] == 3'h6);                // RL16
  wire logic hit_push_s3  = two_byte && (b1[7:6] == 2'h2) && (b1[5:4] == 2'h2)
                            && (b1[2:0] == 3'h0);                                   // RL17
  wire logic hit_push_imm = (b0[7:2] == 6'h1A) && !b0[0];                          // RL18

  assign op_class = hit_to_rm    ? CLS_TO_RM     :
                    hit_from_rm  ? CLS_FROM_RM   :
                    hit_imm_reg  ? CLS_IMM_REG   :
                    hit_acc_ld   ? CLS_ACC_LOAD  :
                    hit_acc_st   ? CLS_ACC_STORE :
                    hit_seg_ld   ? CLS_SEG_LOAD  :
                    hit_seg_st   ? CLS_SEG_STORE :
                    hit_sign_ext ? CLS_SIGN_EXT  :
                    hit_zero_ext ? CLS_ZERO_EXT  :
                    hit_push_s2  ? CLS_PUSH_SEG2 :
                    hit_push_s3  ? CLS_PUSH_SEG3 :
                    hit_push_imm ? CLS_PUSH_IMM  : CLS_NONE;

  // ****************************************************************
  // Operand form and instruction components
  // ****************************************************************
  wire logic has_modrm = hit_to_rm || hit_from_rm || hit_seg_ld || hit_seg_st
                         || hit_sign_ext || hit_zero_ext;
  wire logic mem_rm    = has_modrm && (md != 2'h3);
  wire logic sib_on    = mem_rm && (rm == 3'h4);
  wire logic no_base   = sib_on && (md == 2'h0) && (sib[2:0] == 3'h5);
  wire logic disp_on   = hit_acc_ld || hit_acc_st
                         || (mem_rm && ((md == 2'h1) || (md == 2'h2)
                         || ((md == 2'h0) && (rm == 3'h5)) || no_base));
  wire logic imm_on    = hit_imm_reg || hit_push_imm;

  assign mem_op      = mem_rm || hit_acc_ld || hit_acc_st;
  assign ea_two_reg  = sib_on && (sib[5:3] != 3'h4) && !no_base;                  // RL3
  assign data_access = mem_op || hit_push_s2 || hit_push_s3 || hit_push_imm;
  assign comp_cnt    = 4'h1 + {3'h0, two_byte} + {3'h0, has_modrm} + {3'h0, sib_on}
                       + {3'h0, disp_on} + {3'h0, imm_on};                          // RL6

  // Width bit clear means a byte operand, set means full size.
  assign full_size = (hit_to_rm || hit_from_rm || hit_acc_ld || hit_acc_st) ? b0[0] :
                     hit_imm_reg ? b0[3] :
                     (hit_sign_ext || hit_zero_ext) ? b1[0] : 1'b1;                // RL19

  // ****************************************************************
  // Base clock count
  // ****************************************************************
  always_comb begin
    case (op_class)
      CLS_TO_RM:     base_clk = CLK_XFER;                                            // RL7
      CLS_FROM_RM:   base_clk = dtd_pick(mem_op, CLK_XFER, CLK_LOAD_MEM);           // RL5
      CLS_IMM_REG:   base_clk = CLK_IMM_REG;
      CLS_ACC_LOAD:  base_clk = CLK_ACC_LOAD;
      CLS_ACC_STORE: base_clk = CLK_ACC_STORE;
      CLS_SEG_LOAD:  base_clk = prot_mode ? dtd_pick(mem_op, CLK_SEG_REG_PM, CLK_SEG_MEM_PM)
                                          : dtd_pick(mem_op, CLK_SEG_REG_RM, CLK_SEG_MEM_RM);
      CLS_SEG_STORE: base_clk = CLK_XFER;                                            // RL13
      CLS_SIGN_EXT,
      CLS_ZERO_EXT:  base_clk = dtd_pick(mem_op, CLK_EXT_REG, CLK_EXT_MEM);         // RL14 RL15
      CLS_PUSH_SEG2,
      CLS_PUSH_SEG3,
      CLS_PUSH_IMM:  base_clk = CLK_PUSH;                                            // RL16 RL17
      default:       base_clk = 5'h00;
    endcase
  end

endmodule : dtd_decode

`default_nettype wire

// file: dtd_timing.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// [RL1] Elapsed time is clocks times clock period
// [RL2] Base count only without waits or extras
// [RL3] Two register address components add one
// [RL4] Each wait state adds one clock
// [RL5] Lower count register, higher count memory
// [RL6] Count displacement, immediate, other bytes as components
// [RL7] Register to register/memory transfer: 2 clocks
// [RL8] Register/memory to register: 2 or 4
// [RL9] Immediate to register short form: 2 clocks
// [RL10] Memory to accumulator load: 4 clocks
// [RL11] Accumulator to memory store: 2 clocks
// [RL12] Segment load: 2/5 real, 18/19 protected
// [RL13] Segment store to register/memory: 2 clocks
// [RL14] Sign-extending load: 3 or 6 clocks
// [RL15] Zero-extending load: 3 or 6 clocks
// [RL16] Push legacy segment register: 2 clocks
// [RL17] Push additional segment register: 2 clocks
// [RL18] Push immediate data: 2 clocks
// [RL19] Width bit selects byte or full size
module dtd_timing
  import dtd_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave request
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // AHB-Lite slave response
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata
);

  default clocking dtd_clk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] instr_reg;
  logic [31:0] config_reg;
  logic        valid_reg;
  logic        wr_pend_reg;
  logic [3:0]  wr_ofs_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign hrdata    = hrdata_reg;

  // ****************************************************************
  // Decoder
  // ****************************************************************
  logic [3:0] op_class;
  logic [4:0] base_clk;
  logic       mem_op;
  logic       ea_two_reg;
  logic       full_size;
  logic [3:0] comp_cnt;
  logic       data_access;

  dtd_decode u_decode (
    .instr       (instr_reg),
    .prot_mode   (config_reg[CFG_PROT_BIT]),
    .op_class    (op_class),
    .base_clk    (base_clk),
    .mem_op      (mem_op),
    .ea_two_reg  (ea_two_reg),
    .full_size   (full_size),
    .comp_cnt    (comp_cnt),
    .data_access (data_access)
  );

  // ****************************************************************
  // Cycle count arithmetic
  // ****************************************************************
  wire logic [3:0]  wait_n    = config_reg[CFG_WAIT_LSB +: 4];
  wire logic [2:0]  pfx_n     = config_reg[CFG_PFX_LSB +: 3];
  wire logic        unknown   = (op_class == CLS_NONE);
  wire logic [7:0]  ea_cost   = ea_two_reg ? CLK_EA_TWO_REG : 8'h00;               // RL3
  wire logic [7:0]  wait_cost = data_access ? 8'({4'h0, wait_n} * CLK_PER_WAIT)
                                            : 8'h00;                               // RL4
  wire logic [7:0]  total_clk = {3'h0, base_clk} + ea_cost + wait_cost;
  wire logic [15:0] time_ns   = 16'({8'h00, total_clk} * CLK_PERIOD_NS16);         // RL1
  wire logic [3:0]  comp_all  = comp_cnt + {1'b0, pfx_n};                           // RL6
  wire logic        base_only = valid_reg && !unknown && !ea_two_reg
                                && ((wait_n == 4'h0) || !data_access);              // RL2

  logic [31:0] result_word;
  always_comb begin
    result_word = 32'h0000_0000;
    result_word[RES_TOTAL_LSB +: 8] = total_clk;
    result_word[RES_BASE_LSB +: 5]  = base_clk;
    result_word[RES_MEM_BIT]        = mem_op;
    result_word[RES_EA2_BIT]        = ea_two_reg;
    result_word[RES_FULL_BIT]       = full_size;
    result_word[RES_CLASS_LSB +: 4] = op_class;
    result_word[RES_COMP_LSB +: 4]  = comp_all;
    result_word[RES_VALID_BIT]      = valid_reg;
    result_word[RES_UNKNOWN_BIT]    = unknown;
    result_word[RES_BASEONLY_BIT]   = base_only;
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire logic       addr_ok  = hsel && htrans[1] && hready;
  wire logic       map_hit  = (haddr[11:4] == 8'h00) && (haddr[1:0] == 2'h0);
  wire logic [3:0] ofs      = haddr[3:0];
  wire logic       wr_start = addr_ok && hwrite && map_hit && (hsize == 3'h2);
  wire logic       rd_start = addr_ok && !hwrite;
  wire logic       wr_instr = wr_pend_reg && (wr_ofs_reg == OFS_INSTR);
  wire logic       wr_cfg   = wr_pend_reg && (wr_ofs_reg == OFS_CONFIG);

  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (rd_start && map_hit) begin
      case (ofs)
        OFS_INSTR:  hrdata_next = instr_reg;
        OFS_CONFIG: hrdata_next = config_reg;
        OFS_RESULT: hrdata_next = result_word;
        OFS_TIME:   hrdata_next = {16'h0000, time_ns};
        default:    hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Bus state
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      wr_ofs_reg    <= 4'h0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      hrdata_reg    <= 32'h0000_0000;
    end else begin
      wr_pend_reg   <= wr_start;
      wr_ofs_reg    <= ofs;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      hrdata_reg    <= hrdata_next;
    end
  end

  // A new instruction is decoded as soon as its word lands in the register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_reg  <= INSTR_RST;
      config_reg <= CONFIG_RST;
      valid_reg  <= 1'b0;
    end else begin
      if (wr_instr) begin
        instr_reg <= hwdata;
        valid_reg <= 1'b1;
      end
      if (wr_cfg) begin
        config_reg <= hwdata & CONFIG_MASK;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_xfer_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    (op_class == CLS_TO_RM) |-> (base_clk == 5'h02))
    else $error("register to r/m transfer count wrong");

  a_load_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
    (op_class == CLS_FROM_RM) |-> (base_clk == (mem_op ? 5'h04 : 5'h02)))
    else $error("r/m to register transfer count wrong");

  a_seg_load_mode: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
    (op_class == CLS_SEG_LOAD) |-> (base_clk == (config_reg[CFG_PROT_BIT]
      ? (mem_op ? 5'h13 : 5'h12) : (mem_op ? 5'h05 : 5'h02))))
    else $error("segment load count wrong");

  a_ext_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
    ((op_class == CLS_SIGN_EXT) || (op_class == CLS_ZERO_EXT))
      |-> (base_clk == (mem_op ? 5'h06 : 5'h03)))
    else $error("extending load count wrong");

  a_acc_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
    (op_class == CLS_ACC_LOAD) |-> (base_clk == 5'h04) && mem_op && data_access)
    else $error("accumulator load count wrong");

  a_push_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
    ((op_class == CLS_PUSH_SEG2) || (op_class == CLS_PUSH_SEG3))
      |-> (base_clk == 5'h02) && !mem_op && data_access)
    else $error("segment push count wrong");

  a_push_imm_comp: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    (op_class == CLS_PUSH_IMM) |-> (comp_all == 4'h2 + {1'b0, pfx_n}))
    else $error("immediate push component count wrong");

  a_imm_width: assert property (@(posedge hclk) disable iff (!hresetn) // RL19
    (op_class == CLS_IMM_REG) |-> (full_size == instr_reg[3]))
    else $error("short immediate width wrong");

  a_total_sum: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    total_clk == {3'h0, base_clk} + {7'h00, ea_two_reg}
                 + (data_access ? {4'h0, wait_n} : 8'h00))
    else $error("total clock count wrong");

  a_time_scale: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    time_ns == {8'h00, total_clk} * 16'h0014)
    else $error("elapsed time wrong");

  a_read_result: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    (rd_start && map_hit && (ofs == OFS_RESULT))
      |=> (hrdata == $past(result_word)) && hreadyout && !hresp)
    else $error("result read data wrong");

  a_instr_load: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
    (wr_start && (ofs == OFS_INSTR)) ##1 (hwdata[7:4] == 4'hB)
      |=> (op_class == CLS_IMM_REG) && (base_clk == 5'h02) && valid_reg)
    else $error("written instruction not decoded");

  a_acc_store: assert property ( // RL11
    (op_class == CLS_ACC_STORE)
    |-> (base_clk == 5'h02)
    && mem_op && data_access)
    else $error("store count wrong");

  a_seg_store: assert property ( // RL13
    (op_class == CLS_SEG_STORE)
    |-> (base_clk == 5'h02)
    && full_size)
    else $error("segment store count wrong");

  a_push_imm: assert property ( // RL18
    (op_class == CLS_PUSH_IMM)
    |-> (base_clk == 5'h02)
    && data_access && !mem_op)
    else $error("immediate push count wrong");

  a_imm_reg: assert property ( // RL9
    (op_class == CLS_IMM_REG)
    |-> (base_clk == 5'h02)
    && !data_access)
    else $error("short immediate count wrong");

  a_zero_ext: assert property ( // RL15
    (op_class == CLS_ZERO_EXT)
    |-> (base_clk == (mem_op ? 5'h06 : 5'h03))
    && (full_size == instr_reg[8]))
    else $error("zero extend count wrong");

  a_push_seg3: assert property ( // RL17
    (op_class == CLS_PUSH_SEG3)
    |-> (base_clk == 5'h02)
    && (comp_cnt == 4'h2))
    else $error("long segment push wrong");

  a_two_reg_ea: assert property ( // RL3
    ea_two_reg
    |-> mem_op
    && (total_clk > {3'h0, base_clk}))
    else $error("two register cost missing");

  a_one_reg_ea: assert property ( // RL3
    (mem_op && !ea_two_reg && (wait_n == 4'h0))
    |-> (total_clk == {3'h0, base_clk}))
    else $error("one register cost wrong");

  a_no_access: assert property ( // RL4
    !data_access
    |-> (total_clk == {3'h0, base_clk}))
    else $error("wait cost without access");

  a_wait_added: assert property ( // RL4
    (data_access && !ea_two_reg)
    |-> (total_clk == {3'h0, base_clk} + {4'h0, wait_n}))
    else $error("wait cost wrong");

  a_from_rm_mem: assert property ( // RL5
    ((op_class == CLS_FROM_RM) && mem_op)
    |-> (base_clk > 5'h02))
    else $error("memory count not higher");

  a_ext_reg: assert property ( // RL5
    ((op_class == CLS_SIGN_EXT) && !mem_op)
    |-> (base_clk == 5'h03))
    else $error("register count not lower");

  a_seg_real: assert property ( // RL12
    ((op_class == CLS_SEG_LOAD) && !config_reg[CFG_PROT_BIT])
    |-> (base_clk < 5'h06))
    else $error("real mode segment load wrong");

  a_seg_prot: assert property ( // RL12
    ((op_class == CLS_SEG_LOAD) && config_reg[CFG_PROT_BIT])
    |-> (base_clk > 5'h11))
    else $error("protected segment load wrong");

  a_acc_comp: assert property ( // RL6
    (op_class == CLS_ACC_LOAD)
    |-> (comp_all == 4'h2 + {1'b0, pfx_n}))
    else $error("displacement component wrong");

  a_sib_comp: assert property ( // RL6
    ea_two_reg
    |-> (comp_cnt > 4'h2))
    else $error("index byte component wrong");

  a_unknown_op: assert property ( // RL2
    (op_class == CLS_NONE)
    |-> (base_clk == 5'h00)
    && !base_only)
    else $error("unknown opcode counted");

  a_base_only: assert property ( // RL2
    (valid_reg && !unknown && !ea_two_reg && !data_access)
    |-> base_only)
    else $error("base count flag wrong");

  a_move_width: assert property ( // RL19
    ((op_class == CLS_TO_RM) || (op_class == CLS_FROM_RM))
    |-> (full_size == instr_reg[0]))
    else $error("transfer width wrong");

  a_acc_width: assert property ( // RL19
    ((op_class == CLS_ACC_LOAD) || (op_class == CLS_ACC_STORE))
    |-> (full_size == instr_reg[0]))
    else $error("accumulator width wrong");

endmodule : dtd_timing

`default_nettype wire

// file: dtd_master.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bus master that issues single word transfers to the block
// ****************************************************************
module dtd_master (
  // Clock
  input  wire logic        hclk,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // Response
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Must be entered just after a rising edge; returns just after one.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~a;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Data lines no longer hold the last value once the data phase ends.
    hwdata <= ~wd;
  endtask : xfer
endmodule : dtd_master

`default_nettype wire

// file: test_data_transfer_decode_timing.sv
`timescale 1ns/10ps
`default_nettype none

module test_data_transfer_decode_timing;
  import dtd_pkg::*;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  wire         hsel;
  wire  [31:0] haddr;
  wire  [1:0]  htrans;
  wire         hwrite;
  wire  [2:0]  hsize;
  wire  [31:0] hwdata;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] v;

  always #10 hclk = ~hclk;

  dtd_timing dtd_timing_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );

  dtd_master dtd_master_inst (
    .hclk   (hclk),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata),
    .hready (hreadyout),
    .hrdata (hrdata)
  );

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic stop_test;
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // ****************************************************************
  // Register access
  // ****************************************************************
  task automatic wr(input logic [3:0] ofs, input logic [31:0] d);
    logic [31:0] rd;
    dtd_master_inst.xfer(1'b1, {28'h0, ofs}, d, rd);
  endtask : wr

  task automatic rdreg(input logic [3:0] ofs, output logic [31:0] d);
    dtd_master_inst.xfer(1'b0, {28'h0, ofs}, 32'h0000_0000, d);
  endtask : rdreg

  // Loads one instruction and compares total, base, class and time.
  task automatic run(input logic [31:0] ins, input logic [31:0] cfg, input logic [7:0] tot,
                     input logic [4:0] base, input logic [3:0] cls);
    logic [31:0] r;
    wr(OFS_CONFIG, cfg);
    wr(OFS_INSTR, ins);
    rdreg(OFS_RESULT, r);
    check(r & 32'h000F_1FFF, {12'h000, cls, 3'b000, base, tot});
    rdreg(OFS_TIME, r);
    check(r & 32'h0000_FFFF, 32'(tot) * 32'h0000_0014);
  endtask : run

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdreg(OFS_INSTR, v);
    check(v, INSTR_RST);
    check({31'h0, hresp}, 32'h0);
    rdreg(OFS_CONFIG, v);
    check(v, CONFIG_RST);
    rdreg(OFS_RESULT, v);
    check(v & 32'h0100_0000, 32'h0000_0000);
    wr(OFS_CONFIG, 32'hFFFF_FFFF);
    rdreg(OFS_CONFIG, v);
    check(v, CONFIG_MASK);
    dtd_master_inst.xfer(1'b1, 32'h0000_0010, 32'h1234_5678, v);
    dtd_master_inst.xfer(1'b0, 32'h0000_0010, 32'h0000_0000, v);
    check(v, 32'h0000_0000);
    run(32'h0000_C089, 32'h0, 8'h02, 5'h02, CLS_TO_RM);
    run(32'h0000_0089, 32'h0, 8'h02, 5'h02, CLS_TO_RM);
    run(32'h0000_C08B, 32'h0, 8'h02, 5'h02, CLS_FROM_RM);
    run(32'h0000_008B, 32'h30, 8'h07, 5'h04, CLS_FROM_RM);
    run(32'h0000_048B, 32'h0, 8'h05, 5'h04, CLS_FROM_RM);
    run(32'h0020_048B, 32'h0, 8'h04, 5'h04, CLS_FROM_RM);
    run(32'h0000_00B8, 32'h0, 8'h02, 5'h02, CLS_IMM_REG);
    run(32'h0000_00A1, 32'h0, 8'h04, 5'h04, CLS_ACC_LOAD);
    run(32'h0000_00A3, 32'h10, 8'h03, 5'h02, CLS_ACC_STORE);
    run(32'h0000_D88E, 32'h0, 8'h02, 5'h02, CLS_SEG_LOAD);
    run(32'h0000_188E, 32'h0, 8'h05, 5'h05, CLS_SEG_LOAD);
    run(32'h0000_D88E, 32'h1, 8'h12, 5'h12, CLS_SEG_LOAD);
    run(32'h0000_188E, 32'h1, 8'h13, 5'h13, CLS_SEG_LOAD);
    run(32'h0000_D88C, 32'h0, 8'h02, 5'h02, CLS_SEG_STORE);
    run(32'h0000_188C, 32'h1, 8'h02, 5'h02, CLS_SEG_STORE);
    run(32'h00C0_BE0F, 32'h0, 8'h03, 5'h03, CLS_SIGN_EXT);
    run(32'h0000_BE0F, 32'h0, 8'h06, 5'h06, CLS_SIGN_EXT);
    run(32'h00C0_B60F, 32'h0, 8'h03, 5'h03, CLS_ZERO_EXT);
    run(32'h0000_B60F, 32'h0, 8'h06, 5'h06, CLS_ZERO_EXT);
    run(32'h0000_0006, 32'h20, 8'h04, 5'h02, CLS_PUSH_SEG2);
    run(32'h0000_A00F, 32'h0, 8'h02, 5'h02, CLS_PUSH_SEG3);
    run(32'h0000_A80F, 32'h0, 8'h02, 5'h02, CLS_PUSH_SEG3);
    run(32'h0000_006A, 32'h0, 8'h02, 5'h02, CLS_PUSH_IMM);
    run(32'h0000_0068, 32'h0, 8'h02, 5'h02, CLS_PUSH_IMM);
    run(32'h0000_C089, 32'h300, 8'h02, 5'h02, CLS_TO_RM);
    rdreg(OFS_RESULT, v);
    check(v, 32'h0551_8202);
    wr(OFS_RESULT, 32'hFFFF_FFFF);
    rdreg(OFS_RESULT, v);
    check(v, 32'h0551_8202);
    run(32'h0000_C088, 32'h0, 8'h02, 5'h02, CLS_TO_RM);
    rdreg(OFS_RESULT, v);
    check(v & 32'h0000_8000, 32'h0000_0000);
    run(32'h0000_00B0, 32'h0, 8'h02, 5'h02, CLS_IMM_REG);
    rdreg(OFS_RESULT, v);
    check(v & 32'h0000_8000, 32'h0000_0000);
    wr(OFS_INSTR, 32'h0000_048B);
    rdreg(OFS_RESULT, v);
    check(v & 32'h00F0_6000, 32'h0030_6000);
    wr(OFS_INSTR, 32'h0000_C88E);
    rdreg(OFS_RESULT, v);
    check(v & 32'h0600_0000, 32'h0200_0000);
    stop_test();
  end
endmodule : test_data_transfer_decode_timing

`default_nettype wire
